// ==== bench/buffer_checker.sv ====
`timescale 1ns/100ps
module buffer_checker import buffer_pkg::*; (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic clock_enable_i,
   input wire logic [ADDR_W-1:0] cpu_address_i,
   input wire logic cpu_address_latch_strobe_i,
   input wire logic hold_acknowledge_i,
   input wire logic [ADDR_W-1:0] peripheral_address_lines_o,
   input wire logic [DATA_W-1:0] cpu_data_bus_i,
   input wire logic [DATA_W-1:0] cpu_data_bus_oe_o,
   input wire logic [DATA_W-1:0] memory_data_bus_i,
   input wire logic [DATA_W-1:0] memory_data_bus_o,
   input wire logic [DATA_W-1:0] memory_data_bus_oe_o,
   input wire logic low_byte_check_bit_o,
   input wire logic low_byte_check_bit_oe_o,
   input wire logic read_direction_strobe_i,
   input wire logic action_code_qualifier_i,
   input wire logic conversion_code_high_i,
   input wire logic conversion_code_low_i,
   input wire logic cpu_high_byte_enable_i,
   input wire logic parity_fault_flag_o,
   input wire logic parity_fault_flag_oe_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   a_addr_capture: assert property (clock_enable_i && cpu_address_latch_strobe_i && !hold_acknowledge_i
      |=> peripheral_address_lines_o == $past(cpu_address_i)) else $error("Address not captured");
   a_hold_freezes: assert property (clock_enable_i && hold_acknowledge_i
      |=> $stable(peripheral_address_lines_o)) else $error("Address moved during hold");
   a_read_releases_memory: assert property (clock_enable_i && read_direction_strobe_i
      |=> memory_data_bus_oe_o == 16'h0000 && !low_byte_check_bit_oe_o) else $error("Memory bus driven in read");
   a_read_drives_cpu: assert property (clock_enable_i && read_direction_strobe_i && !hold_acknowledge_i
      |=> cpu_data_bus_oe_o == 16'hFFFF) else $error("CPU bus not driven in read");
   a_cpu_released: assert property (clock_enable_i && !read_direction_strobe_i
      |=> cpu_data_bus_oe_o == 16'h0000) else $error("CPU bus still driven");
   a_check_even: assert property (low_byte_check_bit_oe_o && memory_data_bus_oe_o[7]
      |-> low_byte_check_bit_o == ^memory_data_bus_o[7:0]) else $error("Low check bit not even");
   a_flag_quiet: assert property (!parity_fault_flag_oe_o |-> !parity_fault_flag_o)
      else $error("Fault flag high while disabled");
   a_flag_unqualified: assert property (clock_enable_i && !action_code_qualifier_i
      |=> !parity_fault_flag_o) else $error("Fault flag without qualifier");
   a_flag_off_after: assert property (clock_enable_i && !read_direction_strobe_i ##1
      clock_enable_i && !read_direction_strobe_i |-> !parity_fault_flag_oe_o) else $error("Fault output stuck");
   a_straight_write: assert property (clock_enable_i && !action_code_qualifier_i && !hold_acknowledge_i
      && !read_direction_strobe_i && cpu_high_byte_enable_i
      |=> memory_data_bus_oe_o == 16'hFFFF && memory_data_bus_o == $past(cpu_data_bus_i))
      else $error("Unqualified write not straight");
   a_dma_copy_up: assert property (clock_enable_i && action_code_qualifier_i && conversion_code_high_i
      && !conversion_code_low_i && hold_acknowledge_i && !read_direction_strobe_i
      |=> memory_data_bus_oe_o == 16'hFF00 && memory_data_bus_o[15:8] == $past(memory_data_bus_i[7:0]))
      else $error("DMA high write not copied up");
endmodule

bind data_address_buffer_parity buffer_checker i_checker (.*);

// ==== bench/memory_model.sv ====
`timescale 1ns/100ps
module memory_model (
   input wire logic clock_i,
   input wire logic load_i,
   input wire logic [15:0] load_word_i,
   input wire logic [1:0] corrupt_i,
   input wire logic [15:0] drive_word_i,
   input wire logic [15:0] drive_oe_i,
   input wire logic [1:0] check_i,
   input wire logic [1:0] check_oe_i,
   output logic [15:0] bus_o,
   output logic [1:0] check_o
);
   logic [15:0] store = 16'h0000;
   logic [1:0] parity = 2'h0;
   // Undriven lanes read back what the array holds; a load may plant bad parity
   assign bus_o = (drive_word_i & drive_oe_i) | (store & ~drive_oe_i);
   assign check_o = (check_i & check_oe_i) | (parity & ~check_oe_i);
   always_ff @(posedge clock_i) begin
      if (load_i) begin
         store <= load_word_i;
         parity <= {^load_word_i[15:8], ^load_word_i[7:0]} ^ corrupt_i;
      end else begin
         store <= bus_o;
         parity <= check_o;
      end
   end
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   import buffer_pkg::*;
   logic clock_i = 1'b0, reset_i = 1'b1, clock_enable_i = 1'b1;
   logic [ADDR_W-1:0] cpu_address_i = 16'h0000, peripheral_address_lines_o;
   logic cpu_address_latch_strobe_i = 1'b0, hold_acknowledge_i = 1'b0;
   logic [DATA_W-1:0] cpu_data_bus_i = 16'hA5C3, cpu_data_bus_o, cpu_data_bus_oe_o, read_word_o;
   logic [DATA_W-1:0] memory_data_bus_i, memory_data_bus_o, memory_data_bus_oe_o;
   logic low_byte_check_bit_i, low_byte_check_bit_o, low_byte_check_bit_oe_o;
   logic high_byte_check_bit_i, high_byte_check_bit_o, high_byte_check_bit_oe_o;
   logic read_direction_strobe_i = 1'b0, data_latch_strobe_i = 1'b0, action_code_qualifier_i = 1'b0;
   logic conversion_code_high_i = 1'b0, conversion_code_low_i = 1'b0, cpu_high_byte_enable_i = 1'b0;
   logic parity_fault_flag_o, parity_fault_flag_oe_o, read_word_ready_o, read_word_valid_o;
   logic read_word_accept_i = 1'b1, load = 1'b0;
   logic [15:0] load_word = 16'h0000;
   logic [1:0] corrupt = 2'h0, chk;
   int bad_count = 0, compares = 0;

   assign low_byte_check_bit_i = chk[0];
   assign high_byte_check_bit_i = chk[1];
   data_address_buffer_parity i_dut (.*);
   memory_model i_memory (.clock_i(clock_i), .load_i(load), .load_word_i(load_word), .corrupt_i(corrupt),
      .drive_word_i(memory_data_bus_o), .drive_oe_i(memory_data_bus_oe_o),
      .check_i({high_byte_check_bit_o, low_byte_check_bit_o}),
      .check_oe_i({high_byte_check_bit_oe_o, low_byte_check_bit_oe_o}), .bus_o(memory_data_bus_i), .check_o(chk));

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // Bits: qualifier, code high, code low, hold, high byte enable
   task automatic set_ctl(input logic [4:0] c);
      {action_code_qualifier_i, conversion_code_high_i, conversion_code_low_i} = c[4:2];
      {hold_acknowledge_i, cpu_high_byte_enable_i} = c[1:0];
   endtask
   task automatic test_address();
      cpu_address_i = 16'h8001;
      cpu_address_latch_strobe_i = 1'b1;
      step(1);
      check(peripheral_address_lines_o, 16'h8001);
      cpu_address_i = 16'h7FFE;
      hold_acknowledge_i = 1'b1;
      step(2);
      check(peripheral_address_lines_o, 16'h8001);
      hold_acknowledge_i = 1'b0;
      cpu_address_latch_strobe_i = 1'b0;
      step(1);
      check(peripheral_address_lines_o, 16'h8001);
      // A low clock enable must freeze the latch even with the strobe up
      clock_enable_i = 1'b0;
      cpu_address_latch_strobe_i = 1'b1;
      step(2);
      check(peripheral_address_lines_o, 16'h8001);
      clock_enable_i = 1'b1;
      step(1);
      check(peripheral_address_lines_o, 16'h7FFE);
      cpu_address_latch_strobe_i = 1'b0;
   endtask
   task automatic test_writes();
      logic [4:0] ctl [7] = '{5'h09, 5'h08, 5'h11, 5'h19, 5'h1B, 5'h1F, 5'h15};
      logic [15:0] oe [7] = '{16'hFFFF, 16'h00FF, 16'hFFFF, 16'h00FF, 16'hFF00, 16'h00FF, 16'h0000};
      logic [15:0] md [7] = '{16'hA5C3, 16'h00C3, 16'hA5C3, 16'h00A5, 16'h7B00, 16'h001E, 16'h0000};
      logic [15:0] eff;
      for (int i = 0; i < 7; i++) begin
         load_word = 16'h1E7B;
         load = 1'b1;
         read_direction_strobe_i = 1'b1;
         step(1);
         load = 1'b0;
         read_direction_strobe_i = 1'b0;
         set_ctl(ctl[i]);
         step(1);
         eff = (md[i] & oe[i]) | (16'h1E7B & ~oe[i]);
         check(memory_data_bus_oe_o, oe[i]);
         check(memory_data_bus_o & oe[i], md[i]);
         check({high_byte_check_bit_oe_o, low_byte_check_bit_oe_o}, {2{|oe[i]}});
         if (|oe[i]) check({high_byte_check_bit_o, low_byte_check_bit_o}, {^eff[15:8], ^eff[7:0]});
      end
   endtask
   task automatic do_read(input logic [4:0] c, input logic [15:0] word, input logic [1:0] bad,
         input logic flag, input logic [15:0] want);
      load_word = word;
      corrupt = bad;
      load = 1'b1;
      read_direction_strobe_i = 1'b1;
      step(1);
      load = 1'b0;
      set_ctl(c);
      data_latch_strobe_i = 1'b1;
      step(1);
      check(cpu_data_bus_oe_o, 16'hFFFF);
      check(memory_data_bus_oe_o, 16'h0000);
      data_latch_strobe_i = 1'b0;
      step(2);
      check(parity_fault_flag_oe_o, 1'b1);
      check(parity_fault_flag_o, flag);
      check(cpu_data_bus_o, want);
      read_direction_strobe_i = 1'b0;
      set_ctl(5'h01);
      step(2);
      check(parity_fault_flag_oe_o, 1'b0);
      check(cpu_data_bus_oe_o, 16'h0000);
      check(memory_data_bus_oe_o, 16'hFFFF);
   endtask
   task automatic test_reads();
      do_read(5'h14, 16'hEE5A, 2'h0, 1'b0, 16'h005A);
      do_read(5'h1C, 16'hEE3C, 2'h0, 1'b0, 16'h3C5A);
      do_read(5'h15, 16'h1234, 2'h2, 1'b1, 16'h1234);
      do_read(5'h14, 16'h1234, 2'h2, 1'b0, 16'h1234);
      do_read(5'h14, 16'h1234, 2'h1, 1'b1, 16'h1234);
      do_read(5'h05, 16'h1234, 2'h3, 1'b0, 16'h1234);
   endtask
   task automatic test_fifo();
      int got;
      got = 0;
      read_word_accept_i = 1'b0;
      for (int i = 0; i < 18; i++) do_read(5'h01, 16'h0100 + 16'(i), 2'h0, 1'b0, 16'h0100 + 16'(i));
      check(read_word_ready_o, 1'b0);
      read_word_accept_i = 1'b1;
      for (int i = 0; i < 40; i++) begin
         if (read_word_valid_o === 1'b1) begin
            check(read_word_o, 16'h0100 + 16'(got));
            got++;
         end
         step(1);
      end
      // Sixteen stored plus the output register; the eighteenth word is dropped
      check(16'(got), 16'h0011);
      check(read_word_valid_o, 1'b0);
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      forever #2 clock_i = ~clock_i;
   end
   initial begin
      step(8);
      reset_i = 1'b0;
      step(1);
      test_address();
      test_writes();
      test_reads();
      test_fifo();
      tally_and_finish();
   end
   initial begin
      #20000;
      bad_count++;
      tally_and_finish();
   end
endmodule

// ==== design/buffer_pkg.sv ====
package buffer_pkg;

   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int LANES = 2;
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 8;
   localparam int LANE_LO = 0;
   localparam int LANE_HI = 1;
   localparam int FIFO_DEPTH = 16;

   // Conversion codes, high bit first
   localparam logic [1:0] CODE_WRITE_FULL_LO = 2'h0;
   localparam logic [1:0] CODE_READ_FULL_LO = 2'h1;
   localparam logic [1:0] CODE_WRITE_HI = 2'h2;
   localparam logic [1:0] CODE_READ_HI = 2'h3;

   localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [LANES-1:0] LANES_NONE = 2'h0;
   localparam logic [LANES-1:0] LANES_LO = 2'h1;
   localparam logic [LANES-1:0] LANES_HI = 2'h2;
   localparam logic [LANES-1:0] LANES_BOTH = 2'h3;

   typedef enum logic [1:0] {
      READ_IDLE,
      READ_OPEN,
      READ_CHECKED
   } read_state_t;

   // Even parity: the check bit that makes the byte plus bit even
   function automatic logic even_parity(input logic [BYTE_W-1:0] value);
      even_parity = ^value;
   endfunction

   function automatic logic [BYTE_W-1:0] lane_of(input logic [DATA_W-1:0] word, input int lane);
      lane_of = (lane == LANE_HI) ? word[HI_LSB +: BYTE_W] : word[LO_LSB +: BYTE_W];
   endfunction

endpackage

// ==== design/byte_lane_router.sv ====
`timescale 1ns/100ps
module byte_lane_router (
   input wire logic qualifier_i,
   input wire logic [1:0] code_i,
   input wire logic hold_acknowledge_i,
   input wire logic high_byte_enable_i,
   input wire logic [buffer_pkg::DATA_W-1:0] cpu_word_i,
   input wire logic [buffer_pkg::DATA_W-1:0] memory_word_i,
   output logic [buffer_pkg::DATA_W-1:0] drive_word_o,
   output logic [buffer_pkg::LANES-1:0] drive_lanes_o,
   output logic read_lo_enable_o,
   output logic read_hi_enable_o,
   output logic read_hi_from_low_o
);
   import buffer_pkg::*;

   always_comb begin
      logic cpu_cycle;
      logic [LANES-1:0] cpu_lanes;
      cpu_cycle = ~hold_acknowledge_i;
      cpu_lanes = high_byte_enable_i ? LANES_BOTH : LANES_LO;
      // Straight lanes, no swapping, when the code is not qualified
      drive_word_o = cpu_word_i;
      drive_lanes_o = cpu_cycle ? cpu_lanes : LANES_NONE;
      read_lo_enable_o = cpu_cycle;
      read_hi_enable_o = cpu_cycle & high_byte_enable_i;
      read_hi_from_low_o = 1'b0;
      if (qualifier_i) begin
         case (code_i)
            CODE_WRITE_FULL_LO: begin
               read_lo_enable_o = 1'b0;
               read_hi_enable_o = 1'b0;
            end
            CODE_READ_FULL_LO: begin
               drive_lanes_o = LANES_NONE;
            end
            CODE_WRITE_HI: begin
               read_lo_enable_o = 1'b0;
               read_hi_enable_o = 1'b0;
               if (cpu_cycle) begin
                  drive_word_o[LO_LSB +: BYTE_W] = lane_of(cpu_word_i, LANE_HI);
                  drive_lanes_o = LANES_LO;
               end else begin
                  drive_word_o[HI_LSB +: BYTE_W] = lane_of(memory_word_i, LANE_LO);
                  drive_lanes_o = LANES_HI;
               end
            end
            CODE_READ_HI: begin
               read_lo_enable_o = 1'b0;
               read_hi_enable_o = cpu_cycle;
               read_hi_from_low_o = cpu_cycle;
               if (cpu_cycle) begin
                  drive_lanes_o = LANES_NONE;
               end else begin
                  drive_word_o[LO_LSB +: BYTE_W] = lane_of(memory_word_i, LANE_HI);
                  drive_lanes_o = LANES_LO;
               end
            end
            default: begin
               drive_lanes_o = LANES_NONE;
            end
         endcase
      end
   end
endmodule

// ==== design/data_address_buffer_parity.sv ====
`timescale 1ns/100ps
// Functional notes
// - Peripheral address follows CPU address bit for bit
// - Address latched on strobe unless hold acknowledged
// - Buffered path between CPU and memory data
// - Read latch enabled by direction, hold, code
// - Conversion code obeyed only while qualifier asserted
// - Codes: write, read, high write, high read
// - Full transfers straight lanes; low transfers low only
// - CPU high byte crosses to memory low lane
// - DMA high write copies low lane upward
// - DMA high read copies high lane downward
// - Write cycles drive even parity per byte
// - Qualified read cycles flag odd parity on bytes read
// - Read direction: release memory, drive CPU bus unless hold
// - Read ends: release CPU, drive memory, checks
// - Fault output on after latch, off after read
module data_address_buffer_parity (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic clock_enable_i,
   input wire logic [buffer_pkg::ADDR_W-1:0] cpu_address_i,
   input wire logic cpu_address_latch_strobe_i,
   input wire logic hold_acknowledge_i,
   output logic [buffer_pkg::ADDR_W-1:0] peripheral_address_lines_o,
   input wire logic [buffer_pkg::DATA_W-1:0] cpu_data_bus_i,
   output logic [buffer_pkg::DATA_W-1:0] cpu_data_bus_o,
   output logic [buffer_pkg::DATA_W-1:0] cpu_data_bus_oe_o,
   input wire logic [buffer_pkg::DATA_W-1:0] memory_data_bus_i,
   output logic [buffer_pkg::DATA_W-1:0] memory_data_bus_o,
   output logic [buffer_pkg::DATA_W-1:0] memory_data_bus_oe_o,
   input wire logic low_byte_check_bit_i,
   output logic low_byte_check_bit_o,
   output logic low_byte_check_bit_oe_o,
   input wire logic high_byte_check_bit_i,
   output logic high_byte_check_bit_o,
   output logic high_byte_check_bit_oe_o,
   input wire logic read_direction_strobe_i,
   input wire logic data_latch_strobe_i,
   input wire logic action_code_qualifier_i,
   input wire logic conversion_code_high_i,
   input wire logic conversion_code_low_i,
   input wire logic cpu_high_byte_enable_i,
   output logic parity_fault_flag_o,
   output logic parity_fault_flag_oe_o,
   output logic read_word_ready_o,
   output logic read_word_valid_o,
   output logic [buffer_pkg::DATA_W-1:0] read_word_o,
   input wire logic read_word_accept_i
);
   import buffer_pkg::*;

   logic [DATA_W-1:0] route_word;
   logic [LANES-1:0] route_lanes;
   logic route_read_lo, route_read_hi, route_hi_from_low;
   logic [1:0] code;

   logic [ADDR_W-1:0] next_address;
   logic [DATA_W-1:0] read_latch, next_read_latch;
   logic [DATA_W-1:0] next_cpu_oe;
   logic [DATA_W-1:0] next_memory_out, next_memory_oe;
   logic next_low_check, next_high_check, next_check_oe;
   read_state_t read_state, next_read_state;
   logic strobe_seen, next_strobe_seen;
   logic fault_pending, next_fault_pending;
   logic next_fault_flag, next_fault_oe;
   logic push_valid, next_push_valid;
   logic fifo_in_ready;

   assign code = {conversion_code_high_i, conversion_code_low_i};

   byte_lane_router router (
      .qualifier_i(action_code_qualifier_i),
      .code_i(code),
      .hold_acknowledge_i(hold_acknowledge_i),
      .high_byte_enable_i(cpu_high_byte_enable_i),
      .cpu_word_i(cpu_data_bus_i),
      .memory_word_i(memory_data_bus_i),
      .drive_word_o(route_word),
      .drive_lanes_o(route_lanes),
      .read_lo_enable_o(route_read_lo),
      .read_hi_enable_o(route_read_hi),
      .read_hi_from_low_o(route_hi_from_low)
   );

   // Address latch
   always_comb begin
      next_address = peripheral_address_lines_o;
      if (cpu_address_latch_strobe_i && !hold_acknowledge_i) begin
         next_address = cpu_address_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         peripheral_address_lines_o <= ADDR_RESET;
      end else if (clock_enable_i) begin
         peripheral_address_lines_o <= next_address;
      end
   end

   // Memory side drive and parity generation
   always_comb begin
      logic [DATA_W-1:0] effective;
      logic [DATA_W-1:0] lane_mask;
      logic driving;
      driving = ~read_direction_strobe_i;
      lane_mask = {{BYTE_W{route_lanes[LANE_HI]}}, {BYTE_W{route_lanes[LANE_LO]}}};
      next_memory_out = route_word;
      next_memory_oe = driving ? lane_mask : DATA_RESET;
      // Lanes left to another driver still feed the check bits
      effective = (route_word & lane_mask) | (memory_data_bus_i & ~lane_mask);
      next_low_check = even_parity(lane_of(effective, LANE_LO));
      next_high_check = even_parity(lane_of(effective, LANE_HI));
      next_check_oe = driving && (route_lanes != LANES_NONE);
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         memory_data_bus_o <= DATA_RESET;
         memory_data_bus_oe_o <= DATA_RESET;
         low_byte_check_bit_o <= 1'b0;
         high_byte_check_bit_o <= 1'b0;
         low_byte_check_bit_oe_o <= 1'b0;
         high_byte_check_bit_oe_o <= 1'b0;
      end else if (clock_enable_i) begin
         memory_data_bus_o <= next_memory_out;
         memory_data_bus_oe_o <= next_memory_oe;
         low_byte_check_bit_o <= next_low_check;
         high_byte_check_bit_o <= next_high_check;
         low_byte_check_bit_oe_o <= next_check_oe;
         high_byte_check_bit_oe_o <= next_check_oe;
      end
   end

   // Read latch, parity check and read sequence
   always_comb begin
      logic latch_open, lo_bad, hi_bad, check_hi;
      latch_open = read_direction_strobe_i && data_latch_strobe_i;
      lo_bad = even_parity(lane_of(memory_data_bus_i, LANE_LO)) ^ low_byte_check_bit_i;
      hi_bad = even_parity(lane_of(memory_data_bus_i, LANE_HI)) ^ high_byte_check_bit_i;
      check_hi = route_read_hi && !route_hi_from_low;
      next_read_latch = read_latch;
      next_cpu_oe = DATA_RESET;
      next_read_state = read_state;
      next_strobe_seen = strobe_seen;
      next_fault_pending = fault_pending;
      next_push_valid = 1'b0;
      next_fault_flag = 1'b0;
      next_fault_oe = 1'b0;
      if (read_direction_strobe_i && !hold_acknowledge_i) begin
         next_cpu_oe = {DATA_W{1'b1}};
      end
      if (latch_open) begin
         if (route_read_lo) begin
            next_read_latch[LO_LSB +: BYTE_W] = lane_of(memory_data_bus_i, LANE_LO);
         end
         if (route_read_hi) begin
            next_read_latch[HI_LSB +: BYTE_W] = route_hi_from_low
               ? lane_of(memory_data_bus_i, LANE_LO)
               : lane_of(memory_data_bus_i, LANE_HI);
         end
         // Last sample before the strobe falls decides the fault
         next_fault_pending = (route_read_lo && lo_bad) || (route_hi_from_low && lo_bad)
            || (check_hi && hi_bad);
      end
      case (read_state)
         READ_IDLE: begin
            next_strobe_seen = 1'b0;
            next_fault_pending = latch_open ? next_fault_pending : 1'b0;
            if (read_direction_strobe_i) begin
               next_read_state = READ_OPEN;
               next_strobe_seen = data_latch_strobe_i;
            end
         end
         READ_OPEN: begin
            if (!read_direction_strobe_i) begin
               next_read_state = READ_IDLE;
            end else if (data_latch_strobe_i) begin
               next_strobe_seen = 1'b1;
            end else if (strobe_seen) begin
               next_read_state = READ_CHECKED;
               next_push_valid = !hold_acknowledge_i;
            end
         end
         READ_CHECKED: begin
            if (!read_direction_strobe_i) begin
               next_read_state = READ_IDLE;
            end else if (data_latch_strobe_i) begin
               next_read_state = READ_OPEN;
               next_strobe_seen = 1'b1;
            end
         end
         default: begin
            next_read_state = READ_IDLE;
         end
      endcase
      if (next_read_state == READ_CHECKED) begin
         next_fault_oe = 1'b1;
         next_fault_flag = next_fault_pending && action_code_qualifier_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         read_latch <= DATA_RESET;
         cpu_data_bus_oe_o <= DATA_RESET;
         read_state <= READ_IDLE;
         strobe_seen <= 1'b0;
         fault_pending <= 1'b0;
         parity_fault_flag_o <= 1'b0;
         parity_fault_flag_oe_o <= 1'b0;
         push_valid <= 1'b0;
      end else if (clock_enable_i) begin
         read_latch <= next_read_latch;
         cpu_data_bus_oe_o <= next_cpu_oe;
         read_state <= next_read_state;
         strobe_seen <= next_strobe_seen;
         fault_pending <= next_fault_pending;
         parity_fault_flag_o <= next_fault_flag;
         parity_fault_flag_oe_o <= next_fault_oe;
         push_valid <= next_push_valid;
      end
   end

   assign cpu_data_bus_o = read_latch;
   assign read_word_ready_o = fifo_in_ready;

   // Completed CPU read words; a word offered while full is lost,
   // the controller watches the ready output to avoid that
   read_word_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) read_words (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .enable_i(clock_enable_i),
      .in_valid_i(push_valid),
      .in_data_i(read_latch),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(read_word_valid_o),
      .out_data_o(read_word_o),
      .out_ready_i(read_word_accept_i)
   );
endmodule

// ==== design/read_word_fifo.sv ====
`timescale 1ns/100ps
module read_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] COUNT_FULL = DEPTH[PTR_W:0];
   localparam logic [PTR_W:0] COUNT_ONE = 1;
   localparam logic [PTR_W-1:0] PTR_ONE = 1;

   logic [WIDTH-1:0] store [DEPTH];
   logic [WIDTH-1:0] next_store [DEPTH];
   logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [PTR_W:0] count, next_count;
   logic next_in_ready, next_out_valid;
   logic [WIDTH-1:0] next_out_data;

   // Output word sits in its own register so the port comes from a flop
   always_comb begin
      logic push, head_free, into_head;
      push = in_valid_i & in_ready_o;
      head_free = ~out_valid_o | out_ready_i;
      into_head = 1'b0;
      next_store = store;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      next_out_valid = out_valid_o;
      next_out_data = out_data_o;
      if (head_free) begin
         if (count != '0) begin
            next_out_data = store[rd_ptr];
            next_out_valid = 1'b1;
            next_rd_ptr = rd_ptr + PTR_ONE;
            next_count = count - COUNT_ONE;
         end else if (push) begin
            next_out_data = in_data_i;
            next_out_valid = 1'b1;
            into_head = 1'b1;
         end else begin
            next_out_valid = 1'b0;
         end
      end
      if (push && !into_head) begin
         next_store[wr_ptr] = in_data_i;
         next_wr_ptr = wr_ptr + PTR_ONE;
         next_count = next_count + COUNT_ONE;
      end
      next_in_ready = next_count != COUNT_FULL;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (enable_i) begin
         store <= next_store;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready_o <= next_in_ready;
         out_valid_o <= next_out_valid;
         out_data_o <= next_out_data;
      end
   end
endmodule
